/* File: inc/sfw_pkg.sv */
// constants and types for the subtract-from-accumulator datapath
// Overview of operation
// - literal op: accumulator gets literal minus accumulator; upper byte is the opcode
// - literal op runs decode, read literal, subtract, write accumulator in four phases
// - file op: addressed data register minus accumulator, two's complement
// - destination bit 0 writes accumulator, 1 writes back the data register
// - access bit 0 takes the operand from the fast access bank, ignoring the bank pointer
// - access bit 1 takes the operand bank from the bank pointer register
// - file op reads in phase two, subtracts in three, writes destination in four
// - carry is an inverted borrow, cleared when the subtrahend exceeds the minuend
package sfw_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam int unsigned APB_AW      = 8;
  localparam int unsigned APB_DW      = 32;
  localparam logic [7:0]  OFS_INSTR   = 8'h00;
  localparam logic [7:0]  OFS_ACC     = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_BANK    = 8'h0C;
  localparam logic [7:0]  OFS_MADDR   = 8'h10;
  localparam logic [7:0]  OFS_MDATA   = 8'h14;
  localparam logic [7:0]  OFS_CTRL    = 8'h18;

  // ****************************************
  // instruction fields
  // ****************************************
  localparam int unsigned INSTR_W     = 16;
  localparam logic [7:0]  LIT_OPC     = 8'h08;
  localparam logic [5:0]  FILE_OPC    = 6'h17;
  localparam int unsigned DEST_BIT    = 9;
  localparam int unsigned ACCESS_BIT  = 8;
  localparam logic [7:0]  ACC_SPLIT   = 8'h80;

  // ****************************************
  // status and control bit positions
  // ****************************************
  localparam int unsigned FLG_C       = 0;
  localparam int unsigned FLG_DC      = 1;
  localparam int unsigned FLG_Z       = 2;
  localparam int unsigned FLG_OV      = 3;
  localparam int unsigned FLG_N       = 4;
  localparam int unsigned FLG_W       = 5;
  localparam int unsigned CTL_BUSY    = 0;
  localparam int unsigned CTL_ILLEGAL = 1;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [4:0]  STATUS_RST  = 5'h00;
  localparam logic [15:0] INSTR_RST   = 16'h0000;
  localparam int unsigned Q_PHASES    = 4;

  // ****************************************
  // phase sequencer and memory access stage
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1   = 5'b00010,
    ST_Q2   = 5'b00100,
    ST_Q3   = 5'b01000,
    ST_Q4   = 5'b10000
  } sfw_state_t;

  typedef enum logic [1:0] {
    MPH_NONE   = 2'h0,
    MPH_ISSUED = 2'h1,
    MPH_DONE   = 2'h2
  } sfw_mph_t;

endpackage

/* File: design/sfw_data_mem.sv */
// data memory with registered read port
`timescale 1ns/1ps
`default_nettype none

module sfw_data_mem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 8
)(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // access port
  input  wire logic          i_re,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  generate
    if (AW < 1 || AW > 16 || DW < 1)
    begin : g_bad
      $error("sfw_data_mem: unsupported size");
    end
  endgenerate

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (i_re)
    begin
      rdata_reg <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_reg;

endmodule

`default_nettype wire

/* File: design/sfw_subtract_core.sv */
// subtract-from-accumulator execution datapath with apb register access
`timescale 1ns/1ps
`default_nettype none

module sfw_subtract_core
  import sfw_pkg::*;
#(
  parameter int unsigned BANK_W = 4
)(
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [APB_AW-1:0] I_PADDR,
  input  wire logic [APB_DW-1:0] I_PWDATA,
  output logic      [APB_DW-1:0] O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // core state
  output logic                   O_BUSY
);

  localparam int unsigned MAW = BANK_W + 8;

  generate
    if (BANK_W < 1 || BANK_W > 8)
    begin : g_bad
      $error("sfw_subtract_core: BANK_W out of range");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  // flags in order n, ov, z, dc, c
  function automatic logic [FLG_W-1:0] sub_flags(input logic [7:0] m, input logic [7:0] s);
    logic [8:0]       full;
    logic [4:0]       low;
    logic [FLG_W-1:0] f;
    full = {1'b0, m} - {1'b0, s};
    low  = {1'b0, m[3:0]} - {1'b0, s[3:0]};
    f          = '0;
    f[FLG_C]   = ~full[8];
    f[FLG_DC]  = ~low[4];
    f[FLG_Z]   = (full[7:0] == 8'h00);
    f[FLG_OV]  = (m[7] ^ s[7]) & (m[7] ^ full[7]);
    f[FLG_N]   = full[7];
    return f;
  endfunction

  function automatic logic [MAW-1:0] file_addr(input logic [7:0] f, input logic a,
                                               input logic [BANK_W-1:0] bank);
    logic [BANK_W-1:0] b;
    if (a)
      b = bank;
    else if (f < ACC_SPLIT)
      b = '0;
    else
      b = '1;
    return {b, f};
  endfunction

  // ****************************************
  // state
  // ****************************************
  sfw_state_t        state_reg,  state_next;
  sfw_mph_t          mph_reg,    mph_next;
  logic [15:0]       instr_reg,  instr_next;
  logic [7:0]        acc_reg,    acc_next;
  logic [FLG_W-1:0]  status_reg, status_next;
  logic [BANK_W-1:0] bank_reg,   bank_next;
  logic [MAW-1:0]    maddr_reg,  maddr_next;
  logic              lit_reg,    lit_next;
  logic              file_reg,   file_next;
  logic              illegal_reg, illegal_next;
  logic [MAW-1:0]    opaddr_reg, opaddr_next;
  logic [7:0]        opa_reg,    opa_next;
  logic [7:0]        res_reg,    res_next;
  logic [FLG_W-1:0]  flg_reg,    flg_next;
  logic [31:0]       prdata_reg, prdata_next;

  logic           idle, setup, access, hit, is_mdata, pready, perr, wr_ok;
  logic           mem_go, mem_re, mem_we;
  logic [MAW-1:0] mem_addr;
  logic [7:0]     mem_wdata, mem_rdata, operand;
  logic [31:0]    rd_mux;
  logic           dest_bit, access_bit;

  assign idle       = (state_reg == ST_IDLE);
  assign setup      = I_PSEL & ~I_PENABLE;
  assign access     = I_PSEL & I_PENABLE;
  assign is_mdata   = (I_PADDR == OFS_MDATA);
  assign dest_bit   = instr_reg[DEST_BIT];
  assign access_bit = instr_reg[ACCESS_BIT];
  assign hit        = (I_PADDR == OFS_INSTR) | (I_PADDR == OFS_ACC) | (I_PADDR == OFS_STATUS) |
                      (I_PADDR == OFS_BANK) | (I_PADDR == OFS_MADDR) | is_mdata |
                      (I_PADDR == OFS_CTRL);
  // data window waits for an idle core and the registered memory read
  assign pready     = ~(access & is_mdata) |
                      (I_PWRITE ? (mph_reg == MPH_ISSUED) : (mph_reg == MPH_DONE));
  // unmapped address, or a write outside the data window while an instruction is in flight
  assign perr       = access & pready & (~hit | (I_PWRITE & ~idle & ~is_mdata));
  assign wr_ok      = access & pready & I_PWRITE & ~perr;
  assign mem_go     = access & is_mdata & idle & (mph_reg == MPH_NONE);

  assign O_PREADY  = pready;
  assign O_PSLVERR = perr;
  assign O_PRDATA  = prdata_reg;
  assign O_BUSY    = ~idle;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (I_PADDR)
      OFS_INSTR:  rd_mux[15:0]      = instr_reg;
      OFS_ACC:    rd_mux[7:0]       = acc_reg;
      OFS_STATUS: rd_mux[FLG_W-1:0] = status_reg;
      OFS_BANK:   rd_mux[BANK_W-1:0] = bank_reg;
      OFS_MADDR:  rd_mux[MAW-1:0]   = maddr_reg;
      OFS_CTRL:   rd_mux[1:0]       = {illegal_reg, ~idle};
      default:    rd_mux            = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // memory port
  // ****************************************
  always_comb
  begin
    mem_re    = mem_go & ~I_PWRITE;
    mem_we    = mem_go & I_PWRITE;
    mem_addr  = maddr_reg;
    mem_wdata = I_PWDATA[7:0];
    if (state_reg == ST_Q2 && file_reg)
    begin
      mem_re   = 1'b1;
      mem_addr = file_addr(instr_reg[7:0], access_bit, bank_reg);
    end
    else if (state_reg == ST_Q4 && file_reg && dest_bit)
    begin
      mem_we    = 1'b1;
      mem_addr  = opaddr_reg;
      mem_wdata = res_reg;
    end
  end

  sfw_data_mem #(
    .AW (MAW),
    .DW (8)
  ) u_mem (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_re    (mem_re),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next   = state_reg;
    mph_next     = MPH_NONE;
    instr_next   = instr_reg;
    acc_next     = acc_reg;
    status_next  = status_reg;
    bank_next    = bank_reg;
    maddr_next   = maddr_reg;
    lit_next     = lit_reg;
    file_next    = file_reg;
    illegal_next = illegal_reg;
    opaddr_next  = opaddr_reg;
    opa_next     = opa_reg;
    res_next     = res_reg;
    flg_next     = flg_reg;
    prdata_next  = prdata_reg;
    operand      = lit_reg ? instr_reg[7:0] : mem_rdata;

    if (setup && !I_PWRITE)
      prdata_next = rd_mux;
    if (access && !pready)
    begin
      if (mem_go)
        mph_next = MPH_ISSUED;
      else if (mph_reg == MPH_ISSUED)
      begin
        mph_next    = MPH_DONE;
        prdata_next = {24'h00_0000, mem_rdata};
      end
      else
        mph_next = mph_reg;
    end

    if (wr_ok)
    begin
      case (I_PADDR)
        OFS_INSTR:
        begin
          instr_next   = I_PWDATA[15:0];
          illegal_next = 1'b0;
          state_next   = ST_Q1;
        end
        OFS_ACC:    acc_next    = I_PWDATA[7:0];
        OFS_STATUS: status_next = I_PWDATA[FLG_W-1:0];
        OFS_BANK:   bank_next   = I_PWDATA[BANK_W-1:0];
        OFS_MADDR:  maddr_next  = I_PWDATA[MAW-1:0];
        default:    state_next  = state_reg;
      endcase
    end

    case (state_reg)
      ST_IDLE: state_next = state_next;
      ST_Q1:
      begin
        lit_next  = (instr_reg[15:8] == LIT_OPC);
        file_next = (instr_reg[15:10] == FILE_OPC);
        if (lit_next || file_next)
          state_next = ST_Q2;
        else
        begin
          illegal_next = 1'b1;
          state_next   = ST_IDLE;
        end
      end
      ST_Q2:
      begin
        opaddr_next = file_addr(instr_reg[7:0], access_bit, bank_reg);
        state_next  = ST_Q3;
      end
      ST_Q3:
      begin
        opa_next   = operand;
        res_next   = operand - acc_reg;
        flg_next   = sub_flags(operand, acc_reg);
        state_next = ST_Q4;
      end
      ST_Q4:
      begin
        status_next = flg_reg;
        if (lit_reg || !dest_bit)
          acc_next = res_reg;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_reg   <= ST_IDLE;
      mph_reg     <= MPH_NONE;
      instr_reg   <= INSTR_RST;
      acc_reg     <= ACC_RST;
      status_reg  <= STATUS_RST;
      bank_reg    <= '0;
      maddr_reg   <= '0;
      lit_reg     <= 1'b0;
      file_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      opaddr_reg  <= '0;
      opa_reg     <= 8'h00;
      res_reg     <= 8'h00;
      flg_reg     <= '0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      state_reg   <= state_next;
      mph_reg     <= mph_next;
      instr_reg   <= instr_next;
      acc_reg     <= acc_next;
      status_reg  <= status_next;
      bank_reg    <= bank_next;
      maddr_reg   <= maddr_next;
      lit_reg     <= lit_next;
      file_reg    <= file_next;
      illegal_reg <= illegal_next;
      opaddr_reg  <= opaddr_next;
      opa_reg     <= opa_next;
      res_reg     <= res_next;
      flg_reg     <= flg_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_lit_result;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q1 && instr_reg[15:8] == LIT_OPC)
      |-> ##4 (acc_reg == 8'(instr_reg[7:0] - $past(acc_reg, 4)));
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal result wrong");

  property p_phases;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q1 && (instr_reg[15:8] == LIT_OPC || instr_reg[15:10] == FILE_OPC))
      |=> (state_reg == ST_Q2) ##1 (state_reg == ST_Q3) ##1 (state_reg == ST_Q4)
          ##1 (state_reg == ST_IDLE);
  endproperty
  a_phases: assert property (p_phases) else $error("phase order wrong");

  property p_file_diff;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q3 && file_reg) |=> (res_reg == 8'($past(mem_rdata) - acc_reg));
  endproperty
  a_file_diff: assert property (p_file_diff) else $error("file difference wrong");

  property p_dest_acc;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q4 && file_reg && !dest_bit) |-> !mem_we ##1 (acc_reg == $past(res_reg));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong");

  property p_access_bank;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q2 && file_reg && !access_bit)
      |-> (mem_addr[MAW-1:8] == ((instr_reg[7:0] < ACC_SPLIT) ? '0 : '1));
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("fast access bank wrong");

  property p_bank_ptr;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q2 && file_reg && access_bit) |-> (mem_addr == {bank_reg, instr_reg[7:0]});
  endproperty
  a_bank_ptr: assert property (p_bank_ptr) else $error("bank pointer address wrong");

  property p_file_write;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q2 && file_reg && dest_bit)
      |-> mem_re ##2 (mem_we && mem_addr == $past(mem_addr, 2) && state_reg == ST_Q4);
  endproperty
  a_file_write: assert property (p_file_write) else $error("file write-back wrong");

  property p_carry;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q4) |=> (status_reg[FLG_C] == ($past(opa_reg) >= $past(acc_reg)));
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_zero;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q4) |=> (status_reg[FLG_Z] == ($past(opa_reg) == $past(acc_reg)));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_other_flags;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_reg == ST_Q4) |=> (status_reg[FLG_N] == $past(res_reg[7])) &&
      (status_reg[FLG_DC] == ($past(opa_reg[3:0]) >= $past(acc_reg[3:0]))) &&
      (status_reg[FLG_OV] == (($past(opa_reg[7]) ^ $past(acc_reg[7])) &
                              ($past(opa_reg[7]) ^ $past(res_reg[7]))));
  endproperty
  a_other_flags: assert property (p_other_flags) else $error("n, ov or dc flag wrong");

endmodule

`default_nettype wire

/* File: tb/tb_sfw_subtract_core.sv */
// self-checking testbench for the subtract-from-accumulator datapath
`timescale 1ns/1ps
`default_nettype none

module tb_sfw_subtract_core
  import sfw_pkg::*;
;
  // ****************************************
  // clock, reset and bus signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  int          fails = 0;
  int          checked = 0;
  logic [31:0] seed = 32'h1311;

  always #2 clk = ~clk;

  sfw_subtract_core dut (
    .I_CLK     (clk),
    .I_RST_N   (rst_n),
    .I_PSEL    (psel),
    .I_PENABLE (penable),
    .I_PWRITE  (pwrite),
    .I_PADDR   (paddr),
    .I_PWDATA  (pwdata),
    .O_PRDATA  (prdata),
    .O_PREADY  (pready),
    .O_PSLVERR (pslverr),
    .O_BUSY    (busy)
  );

  // ****************************************
  // reference and helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // flags in the upper five bits, result below
  function automatic logic [12:0] sub_ref(input logic [7:0] m, input logic [7:0] w);
    logic [8:0] r;
    logic [4:0] lo;
    logic [4:0] fl;
    r = {1'b0, m} - {1'b0, w};
    lo = {1'b0, m[3:0]} - {1'b0, w[3:0]};
    fl = 5'h00;
    fl[FLG_C] = ~r[8];
    fl[FLG_DC] = ~lo[4];
    fl[FLG_Z] = (r[7:0] == 8'h00);
    fl[FLG_N] = r[7];
    fl[FLG_OV] = (m[7] != w[7]) && (r[7] != m[7]);
    return {fl, r[7:0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      $display("mismatch at %0t: bus timeout", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, ad, wd, rd, er);
    chk({31'h0, er}, 32'h0, "write error");
  endtask

  task automatic chk_rd(input logic [7:0] ad, input logic [31:0] exp, input string msg);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, ad, 32'h0, rd, er);
    chk(rd, exp, msg);
  endtask

  // counts the cycles that busy stands high
  task automatic wait_idle(output int n);
    n = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (busy === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    if (busy !== 1'b0)
    begin
      fails++;
      $display("mismatch at %0t: core stuck busy", $time);
      print_verdict();
    end
  endtask

  // ****************************************
  // instruction scenarios
  // ****************************************
  task automatic run_lit(input logic [7:0] k, input logic [7:0] w);
    logic [12:0] e;
    int          n;
    e = sub_ref(k, w);
    wr(OFS_ACC, {24'h0, w});
    wr(OFS_INSTR, {16'h0, LIT_OPC, k});
    wait_idle(n);
    chk(n, Q_PHASES, "literal phases");
    chk_rd(OFS_ACC, {24'h0, e[7:0]}, "literal acc");
    chk_rd(OFS_STATUS, {27'h0, e[12:8]}, "literal flags");
  endtask

  task automatic run_file(input logic [7:0] f, input logic d, input logic a,
                          input logic [3:0] bk, input logic [7:0] w, input logic [7:0] m);
    logic [11:0] ad;
    logic [11:0] alt;
    logic [12:0] e;
    int          n;
    ad = a ? {bk, f} : {f[7] ? 4'hF : 4'h0, f};
    alt = a ? {f[7] ? 4'hF : 4'h0, f} : {bk, f};
    e = sub_ref(m, w);
    wr(OFS_BANK, {28'h0, bk});
    wr(OFS_MADDR, {20'h0, alt});
    wr(OFS_MDATA, {24'h0, ~m});
    wr(OFS_MADDR, {20'h0, ad});
    wr(OFS_MDATA, {24'h0, m});
    wr(OFS_ACC, {24'h0, w});
    wr(OFS_INSTR, {16'h0, FILE_OPC, d, a, f});
    wait_idle(n);
    chk(n, Q_PHASES, "file phases");
    chk_rd(OFS_ACC, {24'h0, d ? w : e[7:0]}, "file acc");
    chk_rd(OFS_MDATA, {24'h0, d ? e[7:0] : m}, "file mem");
    chk_rd(OFS_STATUS, {27'h0, e[12:8]}, "file flags");
    if (alt != ad)
    begin
      wr(OFS_MADDR, {20'h0, alt});
      chk_rd(OFS_MDATA, {24'h0, ~m}, "other bank untouched");
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] rd;
    logic        er;
    int          n;
    logic [7:0]  bad [2];
    bad = '{8'h1C, 8'h05};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(OFS_ACC, 32'h0, "acc reset");
    chk_rd(OFS_STATUS, 32'h0, "status reset");
    chk_rd(OFS_BANK, 32'h0, "bank reset");
    foreach (bad[i])
    begin
      apb(1'b0, bad[i], 32'h0, rd, er);
      chk({31'h0, er}, 32'h1, "unmapped access");
    end
    run_lit(8'h02, 8'h01);
    run_lit(8'h02, 8'h02);
    run_lit(8'h02, 8'h03);
    run_lit(8'h80, 8'h01);
    run_lit(8'h00, 8'h80);
    run_file(8'h20, 1'b1, 1'b0, 4'h5, 8'h02, 8'h03);
    run_file(8'h20, 1'b0, 1'b0, 4'h5, 8'h02, 8'h02);
    run_file(8'h90, 1'b1, 1'b0, 4'h3, 8'h02, 8'h01);
    run_file(8'h20, 1'b1, 1'b1, 4'h5, 8'h07, 8'h07);
    run_file(8'hA0, 1'b0, 1'b1, 4'h9, 8'h80, 8'h7F);
    // a register write while the core runs is dropped
    wr(OFS_ACC, 32'h0);
    wr(OFS_INSTR, {16'h0, LIT_OPC, 8'h10});
    apb(1'b1, OFS_ACC, 32'h55, rd, er);
    chk({31'h0, er}, 32'h1, "busy write refused");
    wait_idle(n);
    chk_rd(OFS_ACC, 32'h10, "acc after refused write");
    // unknown opcode: one decode phase, flag raised, accumulator kept
    wr(OFS_INSTR, 32'h0000_FFFF);
    wait_idle(n);
    chk(n, 32'h1, "illegal phases");
    chk_rd(OFS_CTRL, 32'h2, "illegal flag");
    chk_rd(OFS_ACC, 32'h10, "acc after illegal op");
    chk_rd(OFS_INSTR, 32'h0000_FFFF, "instruction readback");
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      run_lit(seed[7:0], seed[15:8]);
      seed = lfsr(seed);
      run_file(seed[7:0], seed[8], seed[9], seed[13:10], seed[23:16], seed[31:24]);
    end
    // reset with the core idle clears acc, status, bank, maddr and ctrl
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(OFS_ACC, 32'h0, "acc after second reset");
    chk_rd(OFS_STATUS, 32'h0, "status after second reset");
    chk_rd(OFS_BANK, 32'h0, "bank after second reset");
    chk_rd(OFS_MADDR, 32'h0, "maddr after second reset");
    chk_rd(OFS_CTRL, 32'h0, "ctrl after second reset");
    print_verdict();
  end
endmodule

`default_nettype wire
